// File: rtl/nvm_pkg.sv
package nvm_pkg;
  // Serial framing
  localparam logic [3:0] TYPE_CODE = 4'ha;
  localparam int ADDR_W = 16;
  localparam int MEM_DEPTH = 65536;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

  // Synchroniser lanes
  localparam int PIN_W = 6;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_STRAP_LSB = 3;
  localparam int STRAP_W = 3;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h03;

  // AHB-Lite slave
  localparam int HADDR_W = 32;
  localparam int HDATA_W = 32;
  localparam int DEC_W = 8;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [DEC_W-1:0] REG_CTRL = 8'h00;
  localparam logic [DEC_W-1:0] REG_STATUS = 8'h04;
  localparam logic [DEC_W-1:0] REG_LAST = 8'h08;
  localparam logic [DEC_W-1:0] REG_DROP = 8'h0c;
  localparam int CTRL_W = 2;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WP_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_BUSY_BIT = 16;
  localparam int STAT_WP_BIT = 17;
  localparam int STAT_RW_BIT = 18;
  localparam int STAT_STATE_LSB = 20;
  localparam int DROP_W = 16;
  localparam logic [DROP_W-1:0] DROP_ONE = 16'h0001;
  localparam logic [HDATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h2,
    ST_SEND = 3'h3,
    ST_MACK = 3'h4,
    ST_HOLD = 3'h5
  } state_t;

  typedef enum logic [1:0] {
    PH_DEV   = 2'h0,
    PH_AHI   = 2'h1,
    PH_ALO   = 2'h2,
    PH_WDATA = 2'h3
  } phase_t;
endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  pin_sync_if.syncer pins
);
  import nvm_pkg::*;

  logic [PIN_W-1:0] meta;
  logic [PIN_W-1:0] stable;

  // Two stages per lane; reset to the idle bus so no false edge appears
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= PIN_IDLE;
      stable <= PIN_IDLE;
    end else begin
      meta <= pins.raw;
      stable <= meta;
    end
  end

  assign pins.synced = stable;
endmodule

// File: rtl/pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if;
  logic [nvm_pkg::PIN_W-1:0] raw;
  logic [nvm_pkg::PIN_W-1:0] synced;
  modport syncer(input raw, output synced);
  modport core(output raw, input synced);
endinterface

// File: rtl/serial_nv_memory_slave.sv
`timescale 1ns/1ps
// Function
// - Data falling while clock high is a start; a transaction begins.
// - Data rising while clock high is a stop; device returns to standby.
// - No write wait after stop; a new transaction may start at once.
// - Receiver pulls data low on the ninth clock after a good byte.
// - Transmitter releases data on the ninth clock for the acknowledge.
// - Stop before an acknowledge aborts the operation to standby.
// - After a not-acknowledge the device releases data; master stops or restarts.
// - First byte: 4-bit type, 3-bit address code, direction bit, MSB first.
// - Only type code 1010 is accepted.
// - Address code bits 2,1,0 must equal the chip select straps.
// - Wrong type or address code: no acknowledge, back to standby.
// - Direction bit 0 means write, 1 means read.
// - Memory address follows as two bytes, high first, each acknowledged.
// - Write: eight bits taken then acknowledged; master waits for it.
// - Read: device drives eight bits, releases, waits for master acknowledge.
// - Input sampled on rising clock, output changed on falling clock.
// - Address acknowledged right after a write, no busy period.
// - Write protect high blocks all writes; reads always allowed. The code refuses reads too while the enable bit is clear.
// - Further write bytes go to incremented addresses, wrapping to zero.
// - Each data byte commits to memory when its acknowledge ends.
// - Counter points one past last byte; current read uses it, wraps.
module serial_nv_memory_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp,
  input wire logic [nvm_pkg::STRAP_W-1:0] chip_select_straps,
  input wire logic hsel,
  input wire logic [nvm_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [nvm_pkg::HDATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [nvm_pkg::HDATA_W-1:0] hrdata
);
  import nvm_pkg::*;

  pin_sync_if pins();

  state_t state;
  phase_t phase;
  logic [3:0] cnt;
  logic [7:0] shift, tx, addr_hi, rx_last;
  logic rw, mack_ok, drive_low;
  logic [ADDR_W-1:0] ptr, ptr_back;
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [7:0] mem_at_ptr, mem_prev;
  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic wp_eff;
  logic [STRAP_W-1:0] straps_s;
  logic dev_match;
  logic byte_full, ack_end, wr_commit, wr_en, tx_load, mack_next;
  logic [CTRL_W-1:0] ctrl;
  logic [DROP_W-1:0] drop_cnt;
  logic bus_wr_pend;
  logic [DEC_W-1:0] bus_addr;
  logic bus_rd_req;
  logic [HDATA_W-1:0] rd_value;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Every pin goes through the two-stage synchroniser before use
  assign pins.raw = {chip_select_straps, wp, sda_in, scl};

  pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pins(pins.syncer)
  );

  assign scl_s = pins.synced[PIN_SCL];
  assign sda_s = pins.synced[PIN_SDA];
  assign straps_s = pins.synced[PIN_STRAP_LSB +: STRAP_W];
  assign wp_eff = pins.synced[PIN_WP] | ctrl[CTRL_WP_BIT];

  // Previous samples for edge and condition detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= PIN_IDLE[PIN_SCL];
      sda_d <= PIN_IDLE[PIN_SDA];
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Clock is input only; data moving under a steady high clock is a condition
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // Address word check: type in the top nibble, straps next, direction last
  assign dev_match = ctrl[CTRL_EN_BIT] && (shift[7:4] == TYPE_CODE)
                     && (shift[3:1] == straps_s);
  assign byte_full = (cnt == BYTE_BITS);

  // Events that other processes act on
  assign ack_end = (state == ST_ACK) && scl_fall;
  assign wr_commit = ack_end && (phase == PH_WDATA);
  assign wr_en = wr_commit && !wp_eff;
  assign mack_next = (state == ST_MACK) && scl_fall && mack_ok;
  assign tx_load = (ack_end && (phase == PH_DEV) && rw) || mack_next;
  assign mem_at_ptr = mem[ptr];
  assign ptr_back = ptr - ADDR_ONE;
  assign mem_prev = mem[ptr_back];

  // Protocol sequencer; stop beats start beats clock edges
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      phase <= PH_DEV;
      cnt <= CNT_ZERO;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      mack_ok <= 1'b0;
      drive_low <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      drive_low <= 1'b0;
    end else if (start_det) begin
      state <= ST_RECV;
      phase <= PH_DEV;
      cnt <= CNT_ZERO;
      drive_low <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_HOLD: begin
          drive_low <= 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && !byte_full) begin
            shift <= {shift[6:0], sda_s};
            cnt <= cnt + CNT_ONE;
          end else if (scl_fall && byte_full) begin
            cnt <= CNT_ZERO;
            if (phase != PH_DEV || dev_match) begin
              state <= ST_ACK;
              drive_low <= 1'b1;
              if (phase == PH_DEV) begin
                rw <= shift[0];
              end
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            drive_low <= 1'b0;
            cnt <= CNT_ZERO;
            unique case (phase)
              PH_DEV: begin
                if (rw) begin
                  state <= ST_SEND;
                  tx <= mem_at_ptr;
                  drive_low <= ~mem_at_ptr[7];
                end else begin
                  state <= ST_RECV;
                  phase <= PH_AHI;
                end
              end
              PH_AHI: begin
                state <= ST_RECV;
                phase <= PH_ALO;
              end
              PH_ALO, PH_WDATA: begin
                state <= ST_RECV;
                phase <= PH_WDATA;
              end
            endcase
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            cnt <= cnt + CNT_ONE;
          end else if (scl_fall) begin
            if (byte_full) begin
              state <= ST_MACK;
              drive_low <= 1'b0;
              mack_ok <= 1'b0;
              cnt <= CNT_ZERO;
            end else begin
              tx <= {tx[6:0], 1'b0};
              drive_low <= ~tx[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ok <= ~sda_s;
            if (sda_s) begin
              state <= ST_HOLD;
            end
          end else if (mack_next) begin
            state <= ST_SEND;
            tx <= mem_at_ptr;
            drive_low <= ~mem_at_ptr[7];
            cnt <= CNT_ZERO;
          end
        end
      endcase
    end
  end

  // Open-drain data: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  // High address byte kept until the low byte completes the pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_hi <= 8'h00;
    end else if (ack_end && phase == PH_AHI) begin
      addr_hi <= shift;
    end
  end

  // Address counter; natural 16-bit overflow gives the wrap to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr <= ADDR_RESET;
    end else if (ack_end && phase == PH_ALO) begin
      ptr <= {addr_hi, shift};
    end else if (wr_commit || tx_load) begin
      ptr <= ptr + ADDR_ONE;
    end
  end

  // Array write at the end of each unprotected data acknowledge, no buffering
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[ptr] <= shift;
    end
  end

  // Last byte seen and count of bytes dropped by write protect
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_last <= 8'h00;
      drop_cnt <= '0;
    end else if (ack_end) begin
      rx_last <= shift;
      if (wr_commit && wp_eff) begin
        drop_cnt <= drop_cnt + DROP_ONE;
      end
    end
  end

  // Bus address phase capture; zero wait states
  assign bus_rd_req = hready && hsel && htrans[HTRANS_ACTIVE_BIT] && !hwrite;

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_wr_pend <= 1'b0;
      bus_addr <= '0;
    end else if (hready) begin
      bus_wr_pend <= hsel && htrans[HTRANS_ACTIVE_BIT] && hwrite;
      bus_addr <= haddr[DEC_W-1:0];
    end
  end

  // Control register, written in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (bus_wr_pend && bus_addr == REG_CTRL) begin
      ctrl <= hwdata[CTRL_W-1:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_value = WORD_ZERO;
    unique case (haddr[DEC_W-1:0])
      REG_CTRL: rd_value[CTRL_W-1:0] = ctrl;
      REG_STATUS: begin
        rd_value[STAT_PTR_LSB +: ADDR_W] = ptr;
        rd_value[STAT_BUSY_BIT] = (state != ST_IDLE);
        rd_value[STAT_WP_BIT] = wp_eff;
        rd_value[STAT_RW_BIT] = rw;
        rd_value[STAT_STATE_LSB +: 3] = state;
      end
      REG_LAST: rd_value[7:0] = rx_last;
      REG_DROP: rd_value[DROP_W-1:0] = drop_cnt;
      default: rd_value = WORD_ZERO;
    endcase
  end

  // Read data registered so it stands through the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= WORD_ZERO;
    end else if (bus_rd_req) begin
      hrdata <= rd_value;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  sequence s_byte_in;
    state == ST_RECV && scl_fall && byte_full && (phase != PH_DEV || dev_match);
  endsequence

  sequence s_dev_bad;
    state == ST_RECV && scl_fall && byte_full && phase == PH_DEV && !dev_match;
  endsequence

  sequence s_dev_read;
    state == ST_ACK && scl_fall && phase == PH_DEV && rw;
  endsequence

  a_stop_idle: assert property (stop_det |=> state == ST_IDLE && !drive_low)
    else $error("stop did not return to standby");
  a_start_dev: assert property (start_det |=>
    state == ST_RECV && phase == PH_DEV && cnt == CNT_ZERO)
    else $error("start did not open an address word");
  a_ack_drive: assert property (s_byte_in |=> state == ST_ACK && drive_low)
    else $error("good byte not acknowledged");
  a_ack_hold: assert property (state == ST_ACK && !scl_fall && !start_det && !stop_det
    |=> drive_low)
    else $error("acknowledge dropped early");
  a_addr_match: assert property ($rose(state == ST_ACK) && phase == PH_DEV |->
    shift[7:4] == TYPE_CODE && shift[3:1] == straps_s)
    else $error("foreign address acknowledged");
  a_dev_reject: assert property (s_dev_bad |=> state == ST_IDLE && !drive_low)
    else $error("mismatched address not rejected");
  a_mack_release: assert property (state == ST_MACK |-> !drive_low)
    else $error("data held during master acknowledge");
  a_nack_hold: assert property (state == ST_MACK && scl_rise && sda_s && !stop_det
    |=> state == ST_HOLD ##1 !drive_low)
    else $error("nack did not release the line");
  a_out_fall: assert property ($changed(drive_low) |->
    $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("data changed off a falling edge");
  a_commit_data: assert property (wr_en |=>
    mem_prev == $past(shift) && ptr_back == $past(ptr))
    else $error("byte not committed at its address");
  a_wp_keep: assert property (wr_commit && wp_eff |=> mem_prev == $past(mem_at_ptr))
    else $error("protected location changed");
  a_read_load: assert property (s_dev_read |=>
    state == ST_SEND && tx == $past(mem_at_ptr) && ptr_back == $past(ptr))
    else $error("read byte not taken from counter");
endmodule

// File: tb/i2c_master_model.sv
`timescale 1ns/1ps
// Two-wire bus master; its clock rests high between frames
module i2c_master_model (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  int glitches = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of a 160 ns bit period
  task automatic qtr();
    repeat (2) @(posedge clk);
  endtask
  // Data falls while the clock is high
  task automatic start();
    sda_low <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask
  // Data rises while the clock is high
  task automatic stop();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask
  // Data moves in the low phase only; the line must not move while high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda;
    qtr();
    if (sda !== r) glitches++;
    scl <= 1'b0;
    qtr();
  endtask
  // Ninth clock left released for the answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// File: tb/test_serial_nv_memory_slave.sv
`timescale 1ns/1ps
module test_serial_nv_memory_slave;
  import nvm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wp = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [2:0] straps = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic sda_out, sda_oe, hreadyout, hresp, scl, m_low, ack;
  logic [7:0] b, lastb;
  logic [7:0] bad [3];
  wire sda;
  logic [7:0] mem [int];
  int ptr = 0, drops = 0, num_errors = 0, checks_done = 0, cyc = 0;
  integer seed = 32'hbe6c_852f;

  // Pull-up unless a party pulls low
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  initial begin
    forever #10 clk = ~clk;
  end
  serial_nv_memory_slave i_serial_nv_memory_slave (.clk(clk), .rst(rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .chip_select_straps(straps),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  i2c_master_model i_master (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Single word transfer; waits on the slave's ready, never a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic addr_phase(input logic [15:0] a);
    i_master.start();
    i_master.wbyte({TYPE_CODE, straps, 1'b0}, ack);
    chk("ack_dev", 1, 32'(ack));
    i_master.wbyte(a[15:8], ack);
    chk("ack_hi", 1, 32'(ack));
    i_master.wbyte(a[7:0], ack);
    chk("ack_lo", 1, 32'(ack));
    ptr = a;
  endtask
  // Model keeps the array and the counter; protected bytes are dropped
  task automatic wr(input logic [15:0] a, input int n, input logic prot);
    addr_phase(a);
    repeat (n) begin
      b = 8'($random(seed));
      lastb = b;
      i_master.wbyte(b, ack);
      chk("ack_data", 1, 32'(ack));
      if (prot) drops++;
      else mem[ptr] = b;
      ptr = (ptr + 1) % MEM_DEPTH;
    end
    i_master.stop();
  endtask
  task automatic rdx(input logic seta, input logic [15:0] a, input int n);
    if (seta) addr_phase(a);
    i_master.start();
    i_master.wbyte({TYPE_CODE, straps, 1'b1}, ack);
    chk("ack_rd", 1, 32'(ack));
    for (int i = 0; i < n; i++) begin
      i_master.rbyte(i == n - 1, b);
      chk("rdata", 32'(mem[ptr]), 32'(b));
      ptr = (ptr + 1) % MEM_DEPTH;
    end
    repeat (4) @(posedge clk);
    chk("released", 0, 32'(sda_oe));
    i_master.stop();
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    chk("rst_oe", 0, 32'(sda_oe));
    chk("rst_hrdata", 0, hrdata);
    rst <= 1'b0;
    straps <= 3'($random(seed));
    repeat (8) @(posedge clk);
    ahb(1'b0, REG_CTRL, 0);
    chk("ctrl", 32'(CTRL_RESET), rd);
    chk("hresp", 0, 32'(hresp));
    chk("hready", 1, 32'(hreadyout));
    // Page write across the top address, then stop and restart at once
    wr(16'hfffe, 4, 1'b0);
    ahb(1'b0, REG_LAST, 0);
    chk("last", 32'(lastb), {24'h00_0000, rd[7:0]});
    rdx(1'b1, 16'hfffe, 3);
    rdx(1'b0, 16'h0000, 1);
    ahb(1'b0, REG_STATUS, 0);
    chk("ptr", 32'(ptr), {16'h0000, rd[15:0]});
    // Wrong type, top strap off, lowest strap off
    bad = '{{4'hb, straps, 1'b0}, {TYPE_CODE, straps ^ 3'h4, 1'b0},
            {TYPE_CODE, straps ^ 3'h1, 1'b1}};
    for (int i = 0; i < 3; i++) begin
      i_master.start();
      i_master.wbyte(bad[i], ack);
      chk("nack", 0, 32'(ack));
      ahb(1'b0, REG_STATUS, 0);
      chk("idle", 0, 32'(rd[STAT_BUSY_BIT]));
      i_master.stop();
    end
    // Pin then soft protect: acknowledged, but the array keeps its byte
    for (int i = 0; i < 2; i++) begin
      if (i == 0) wp <= 1'b1;
      else ahb(1'b1, REG_CTRL, 32'h0000_0003);
      wr(16'h0001, 1, 1'b1);
      wp <= 1'b0;
    end
    // Disabled slave ignores even its own address
    ahb(1'b1, REG_CTRL, 32'h0000_0000);
    i_master.start();
    i_master.wbyte({TYPE_CODE, straps, 1'b1}, ack);
    chk("nack_off", 0, 32'(ack));
    i_master.stop();
    ahb(1'b1, REG_CTRL, 32'h0000_0001);
    ahb(1'b0, REG_DROP, 0);
    chk("drops", 32'(drops), {16'h0000, rd[15:0]});
    rdx(1'b1, 16'h0001, 1);
    // Stop in the middle of a byte
    i_master.start();
    i_master.wbyte({TYPE_CODE, straps, 1'b0}, ack);
    repeat (4) i_master.bit_io(1'b0, ack);
    i_master.stop();
    ahb(1'b0, REG_STATUS, 0);
    chk("abort", 0, 32'(rd[22:16]));
    ahb(1'b0, 8'h10, 0);
    chk("unmapped", 0, rd);
    chk("glitches", 0, 32'(i_master.glitches));
    finish_test();
  end
endmodule
